// File: pkg/acac_defines.vh
// Purpose: Shared constants for the alarm annunciation controller
// Assumes: 10 MHz core clock, 32-bit APB register bus
// Notes: Definitions only
`ifndef ACAC_DEFINES_VH
`define ACAC_DEFINES_VH
`define ACAC_CLK_HZ 10000000
`define ACAC_SCROLL_TIMEOUT_S 15
`define ACAC_CADENCE_HALF_MS 500
`define ACAC_ZONE_MSG_CHARS 32
`define ACAC_DEV_MSG_CHARS 26
`define ACAC_ADDR_OUT_ENABLE 8'h00
`define ACAC_ADDR_SILENCEABLE 8'h04
`define ACAC_ADDR_STATUS 8'h08
`define ACAC_ADDR_COUNTS 8'h0C
`define ACAC_ADDR_OTHER_COUNT 8'h10
`define ACAC_OUT_ENABLE_RST 32'hFFFFFFFF
`define ACAC_SILENCEABLE_RST 32'hFFFFFFFF
`define ACAC_KEY_ACK 0
`define ACAC_KEY_SCROLL 1
`define ACAC_KEY_SILENCE 2
`define ACAC_KEY_RESOUND 3
`define ACAC_KEY_RESET 4
`define ACAC_KEY_VIEW 5
`define ACAC_NUM_KEYS 6
`define ACAC_CAT_ALARM 3'h1
`define ACAC_CAT_MNS 3'h2
`define ACAC_CAT_SUPV 3'h4
`define ACAC_CAT_NONE 3'h0
`endif

// File: logic/acac_event_store.v
// Purpose: Arrival-ordered store of events for one category
// Assumes: Push pulses come from logic on the core clock
// Notes: Pushes beyond DEPTH are counted nowhere and dropped
`timescale 1ns/10ps
`default_nettype none
module acac_event_store #(
	parameter DEPTH = 16,
	parameter AW = 4,
	parameter DW = 28
) (
	input wire core_clk_i,
	input wire rst_i,
	input wire clr_i,
	input wire push_i,
	input wire [DW-1:0] data_i,
	input wire [AW-1:0] rd_idx_i,
	output wire [DW-1:0] rd_data_o,
	output reg [AW:0] count_o
);
	reg [DW-1:0] mem [0:DEPTH-1];
	wire full;

	assign full = (count_o == DEPTH[AW:0]);
	assign rd_data_o = mem[rd_idx_i];

	always @(posedge core_clk_i) begin
		if (rst_i || clr_i) begin
			count_o <= {(AW+1){1'b0}};
		end else if (push_i && !full) begin
			mem[count_o[AW-1:0]] <= data_i;
			count_o <= count_o + 1'b1;
		end
	end
endmodule // acac_event_store
`default_nettype wire

// File: logic/acac_annunciator.v
// Purpose: Alarm-state annunciation, display selection and operator keys
// Assumes: Keys arrive from pins; event strobes come from core-clock logic
// Notes: Registers reached over APB, zero wait states
// Functional notes
// R1: In alarm, display only alarm, mass notification and supervisory events.
// R2: Other events stay counted and viewable through the menu view key.
// R3: New alarm flashes alarm LED, sounds buzzer steadily, shows new zone.
// R4: Display zone message of 32 chars, device message 26, device type.
// R5: Keep three category counts, shown on highlighted bottom line.
// R6: During alarm show first alarm plus the counts.
// R7: Scroll works only with more than one viewable event.
// R8: Acknowledge makes LED steady, silences buzzer, marks alarm acknowledged.
// R9: One acknowledge press acknowledges every active event.
// R10: Scroll order alarms, mass notification, supervisory; ordinal within category.
// R11: Fifteen seconds without scroll key returns display to first alarm.
// R12: Later event flashes its LED, raises count, re-sounds buzzer by category.
// R13: Later events never move the display away from the first alarm.
// R14: Alarm drives outputs per installer per-output programming.
// R15: Silence turns off silenceable circuits; all silenceable by default.
// R16: Resound restores exactly the circuits silence turned off.
// R17: Reset clears alarm and latched conditions, back to standby.
// R18: Pulsed buzzer cadence derived from clock, period is a parameter.
`timescale 1ns/10ps
`default_nettype none
`include "acac_defines.vh"
module acac_annunciator #(
	parameter DEPTH = 16,
	parameter AW = 4,
	parameter NUM_OUT = 8,
	parameter SCROLL_TIMEOUT_CYC = `ACAC_SCROLL_TIMEOUT_S * `ACAC_CLK_HZ,
	parameter CADENCE_HALF_CYC = (`ACAC_CADENCE_HALF_MS * (`ACAC_CLK_HZ / 1000))
) (
	input wire core_clk_i,
	input wire rst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	input wire alarm_evt_i,
	input wire [27:0] alarm_info_i,
	input wire mass_notification_evt_i,
	input wire [27:0] mass_notification_info_i,
	input wire supv_evt_i,
	input wire [27:0] supv_info_i,
	input wire other_evt_i,
	input wire [`ACAC_NUM_KEYS-1:0] keys_i,
	output reg alarm_led_o,
	output reg mass_notification_led_o,
	output reg supv_led_o,
	output reg buzzer_o,
	output reg [NUM_OUT-1:0] notification_appliance_circuit_o,
	output reg silenced_led_o,
	output reg [2:0] disp_cat_o,
	output reg [AW:0] disp_ordinal_o,
	output reg disp_new_o,
	output reg disp_scroll_o,
	output reg [15:0] disp_zone_o,
	output reg [15:0] disp_zone_msg_addr_o,
	output reg [15:0] disp_dev_msg_addr_o,
	output reg [3:0] disp_dev_type_o,
	output reg [AW:0] alarm_count_o,
	output reg [AW:0] mass_notification_count_o,
	output reg [AW:0] supv_count_o,
	output reg show_other_o,
	output reg [15:0] other_count_o
);
	reg [`ACAC_NUM_KEYS-1:0] key_meta;
	reg [`ACAC_NUM_KEYS-1:0] key_sync;
	reg [`ACAC_NUM_KEYS-1:0] key_prev;
	wire [`ACAC_NUM_KEYS-1:0] key_press;
	wire ack_key;
	wire scroll_key;
	wire silence_key;
	wire resound_key;
	wire reset_key;
	wire view_key;
	reg [31:0] out_enable;
	reg [31:0] silenceable;
	reg alarm_unack;
	reg mns_unack;
	reg supv_unack;
	reg buzz_cont;
	reg buzz_pulse;
	reg [NUM_OUT-1:0] silenced_mask;
	reg view_active;
	reg [AW+1:0] scroll_idx;
	reg [31:0] idle_cnt;
	reg [31:0] cad_cnt;
	reg phase;
	wire [AW:0] n_alarm;
	wire [AW:0] n_mns;
	wire [AW:0] n_supv;
	wire [AW+1:0] total;
	wire [27:0] rd_alarm;
	wire [27:0] rd_mns;
	wire [27:0] rd_supv;
	wire alarm_active;
	wire [NUM_OUT-1:0] out_active;
	reg [2:0] next_cat;
	reg [AW:0] next_pos;
	reg [27:0] next_info;
	reg [31:0] next_rdata;
	wire setup;
	wire wr;
	wire [31:0] zone_msg_prod;
	wire [31:0] dev_msg_prod;

	function [AW+1:0] ext;
		input [AW:0] v;
		begin
			ext = {1'b0, v};
		end
	endfunction

	// Pins cross into the core domain; only key_sync and key_prev are looked at
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			key_meta <= {`ACAC_NUM_KEYS{1'b0}};
			key_sync <= {`ACAC_NUM_KEYS{1'b0}};
			key_prev <= {`ACAC_NUM_KEYS{1'b0}};
		end else begin
			key_meta <= keys_i;
			key_sync <= key_meta;
			key_prev <= key_sync;
		end
	end
	assign key_press = key_sync & ~key_prev;
	assign ack_key = key_press[`ACAC_KEY_ACK];
	assign scroll_key = key_press[`ACAC_KEY_SCROLL];
	assign silence_key = key_press[`ACAC_KEY_SILENCE];
	assign resound_key = key_press[`ACAC_KEY_RESOUND];
	assign reset_key = key_press[`ACAC_KEY_RESET];
	assign view_key = key_press[`ACAC_KEY_VIEW];

	acac_event_store #(.DEPTH(DEPTH), .AW(AW), .DW(28)) u_alarm (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.clr_i(reset_key), // R17
		.push_i(alarm_evt_i), // R5
		.data_i(alarm_info_i),
		.rd_idx_i(next_pos[AW-1:0]),
		.rd_data_o(rd_alarm),
		.count_o(n_alarm)
	);
	acac_event_store #(.DEPTH(DEPTH), .AW(AW), .DW(28)) u_mns (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.clr_i(reset_key), // R17
		.push_i(mass_notification_evt_i), // R5
		.data_i(mass_notification_info_i),
		.rd_idx_i(next_pos[AW-1:0]),
		.rd_data_o(rd_mns),
		.count_o(n_mns)
	);
	acac_event_store #(.DEPTH(DEPTH), .AW(AW), .DW(28)) u_supv (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.clr_i(reset_key), // R17
		.push_i(supv_evt_i), // R5
		.data_i(supv_info_i),
		.rd_idx_i(next_pos[AW-1:0]),
		.rd_data_o(rd_supv),
		.count_o(n_supv)
	);

	assign alarm_active = (n_alarm != {(AW+1){1'b0}});
	assign total = ext(n_alarm) + ext(n_mns) + ext(n_supv);

	// Acknowledge and buzzer state; a new event wins over a same-cycle ack
	always @(posedge core_clk_i) begin
		if (rst_i || reset_key) begin // R17
			alarm_unack <= 1'b0;
			mns_unack <= 1'b0;
			supv_unack <= 1'b0;
			buzz_cont <= 1'b0;
			buzz_pulse <= 1'b0;
		end else begin
			if (ack_key) begin // R8 R9
				alarm_unack <= 1'b0;
				mns_unack <= 1'b0;
				supv_unack <= 1'b0;
				buzz_cont <= 1'b0;
				buzz_pulse <= 1'b0;
			end
			if (alarm_evt_i) begin // R3 R12
				alarm_unack <= 1'b1;
				buzz_cont <= 1'b1;
			end
			if (mass_notification_evt_i) begin // R12
				mns_unack <= 1'b1;
				buzz_pulse <= 1'b1;
			end
			if (supv_evt_i) begin // R12
				supv_unack <= 1'b1;
				buzz_pulse <= 1'b1;
			end
		end
	end

	// Fixed cadence shared by LED flashing and the pulsed buzzer
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			cad_cnt <= 32'h00000000;
			phase <= 1'b1;
		end else if (cad_cnt >= CADENCE_HALF_CYC - 1) begin // R18
			cad_cnt <= 32'h00000000;
			phase <= ~phase;
		end else begin
			cad_cnt <= cad_cnt + 32'h00000001;
		end
	end

	// Scroll position; new events never move it
	always @(posedge core_clk_i) begin
		if (rst_i || reset_key) begin
			scroll_idx <= {(AW+2){1'b0}};
			idle_cnt <= 32'h00000000;
		end else if (scroll_key && total > ext({{AW{1'b0}}, 1'b1})) begin // R7
			scroll_idx <= (scroll_idx + 1'b1 >= total) ? {(AW+2){1'b0}} : scroll_idx + 1'b1;
			idle_cnt <= 32'h00000000;
		end else if (scroll_idx != {(AW+2){1'b0}}) begin
			if (idle_cnt >= SCROLL_TIMEOUT_CYC - 1) begin // R11
				scroll_idx <= {(AW+2){1'b0}};
				idle_cnt <= 32'h00000000;
			end else begin
				idle_cnt <= idle_cnt + 32'h00000001;
			end
		end else begin
			idle_cnt <= 32'h00000000;
		end
	end

	// Map the scroll position to category and ordinal
	always @* begin
		next_cat = `ACAC_CAT_NONE;
		next_pos = {(AW+1){1'b0}};
		next_info = 28'h0000000;
		if (scroll_idx < ext(n_alarm)) begin // R6 R10 R13
			next_cat = `ACAC_CAT_ALARM;
			next_pos = scroll_idx[AW:0];
			next_info = rd_alarm;
		end else if (scroll_idx < ext(n_alarm) + ext(n_mns)) begin // R10
			next_cat = `ACAC_CAT_MNS;
			next_pos = scroll_idx[AW:0] - n_alarm;
			next_info = rd_mns;
		end else if (scroll_idx < total) begin // R10
			next_cat = `ACAC_CAT_SUPV;
			next_pos = scroll_idx[AW:0] - n_alarm - n_mns;
			next_info = rd_supv;
		end
	end

	// Outputs steered by installer programming; silence remembers what it cut
	assign out_active = alarm_active ? out_enable[NUM_OUT-1:0] : {NUM_OUT{1'b0}}; // R14
	always @(posedge core_clk_i) begin
		if (rst_i || reset_key) begin // R17
			silenced_mask <= {NUM_OUT{1'b0}};
		end else if (alarm_evt_i || resound_key) begin // R16
			silenced_mask <= {NUM_OUT{1'b0}};
		end else if (silence_key) begin // R15
			silenced_mask <= out_active & silenceable[NUM_OUT-1:0];
		end
	end

	// Menu view reveals suppressed events; their count saturates at 16'hFFFF and the reset key clears it
	always @(posedge core_clk_i) begin
		if (rst_i || reset_key) begin
			view_active <= 1'b0;
			other_count_o <= 16'h0000;
		end else begin
			if (view_key) begin
				view_active <= ~view_active; // R2
			end
			if (other_evt_i && other_count_o != 16'hFFFF) begin
				other_count_o <= other_count_o + 16'h0001; // R2
			end
		end
	end

	// Message fields are fixed-size slots in the text memory
	assign zone_msg_prod = next_info[27:12] * `ACAC_ZONE_MSG_CHARS; // R4
	assign dev_msg_prod = next_info[11:4] * `ACAC_DEV_MSG_CHARS; // R4

	// Registered indicator, output and display drive
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			alarm_led_o <= 1'b0;
			mass_notification_led_o <= 1'b0;
			supv_led_o <= 1'b0;
			buzzer_o <= 1'b0;
			notification_appliance_circuit_o <= {NUM_OUT{1'b0}};
			silenced_led_o <= 1'b0;
			disp_cat_o <= `ACAC_CAT_NONE;
			disp_ordinal_o <= {(AW+1){1'b0}};
			disp_new_o <= 1'b0;
			disp_scroll_o <= 1'b0;
			disp_zone_o <= 16'h0000;
			disp_zone_msg_addr_o <= 16'h0000;
			disp_dev_msg_addr_o <= 16'h0000;
			disp_dev_type_o <= 4'h0;
			alarm_count_o <= {(AW+1){1'b0}};
			mass_notification_count_o <= {(AW+1){1'b0}};
			supv_count_o <= {(AW+1){1'b0}};
			show_other_o <= 1'b0;
		end else begin
			alarm_led_o <= alarm_active & (~alarm_unack | phase); // R3 R8
			mass_notification_led_o <= (n_mns != {(AW+1){1'b0}}) & (~mns_unack | phase); // R12
			supv_led_o <= (n_supv != {(AW+1){1'b0}}) & (~supv_unack | phase); // R12
			buzzer_o <= buzz_cont | (buzz_pulse & phase); // R3 R12 R18
			notification_appliance_circuit_o <= out_active & ~silenced_mask; // R14 R15 R16
			silenced_led_o <= (silenced_mask != {NUM_OUT{1'b0}});
			disp_cat_o <= next_cat;
			disp_ordinal_o <= next_pos + 1'b1; // R10
			disp_new_o <= (next_cat == `ACAC_CAT_ALARM) ? alarm_unack :
				(next_cat == `ACAC_CAT_MNS) ? mns_unack :
				(next_cat == `ACAC_CAT_SUPV) ? supv_unack : 1'b0; // R3 R8
			disp_scroll_o <= (total > ext({{AW{1'b0}}, 1'b1})); // R7
			disp_zone_o <= next_info[27:12]; // R3
			disp_zone_msg_addr_o <= zone_msg_prod[15:0]; // R4
			disp_dev_msg_addr_o <= dev_msg_prod[15:0]; // R4
			disp_dev_type_o <= next_info[3:0]; // R4
			alarm_count_o <= n_alarm; // R5
			mass_notification_count_o <= n_mns; // R5
			supv_count_o <= n_supv; // R5
			show_other_o <= ~alarm_active | view_active; // R1 R2
		end
	end

	// APB slave: read data captured in setup, answered with no wait state
	assign setup = psel_i & ~penable_i;
	assign wr = psel_i & penable_i & pwrite_i;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & (paddr_i > `ACAC_ADDR_OTHER_COUNT || paddr_i[1:0] != 2'h0
		|| (pwrite_i && paddr_i > `ACAC_ADDR_SILENCEABLE));

	always @* begin
		case (paddr_i)
			`ACAC_ADDR_OUT_ENABLE: next_rdata = out_enable;
			`ACAC_ADDR_SILENCEABLE: next_rdata = silenceable;
			`ACAC_ADDR_STATUS: next_rdata = {26'h0000000, view_active,
				(silenced_mask != {NUM_OUT{1'b0}}), supv_unack, mns_unack, alarm_unack, alarm_active};
			`ACAC_ADDR_COUNTS: next_rdata = {8'h00, {(8-AW-1){1'b0}}, n_supv,
				{(8-AW-1){1'b0}}, n_mns, {(8-AW-1){1'b0}}, n_alarm};
			`ACAC_ADDR_OTHER_COUNT: next_rdata = {16'h0000, other_count_o};
			default: next_rdata = 32'h00000000;
		endcase
	end

	always @(posedge core_clk_i) begin
		if (rst_i) begin
			prdata_o <= 32'h00000000;
			out_enable <= `ACAC_OUT_ENABLE_RST;
			silenceable <= `ACAC_SILENCEABLE_RST; // R15
		end else begin
			if (setup) begin
				prdata_o <= next_rdata;
			end
			if (wr && paddr_i == `ACAC_ADDR_OUT_ENABLE) begin
				out_enable <= pwdata_i; // R14
			end
			if (wr && paddr_i == `ACAC_ADDR_SILENCEABLE) begin
				silenceable <= pwdata_i;
			end
		end
	end
endmodule // acac_annunciator
`default_nettype wire

// File: testbench/acac_annunciator_monitor.sv
// Purpose: Concurrent checks at the annunciator ports
// Assumes: Bench shortens scroll timeout and cadence
// Notes: Key checks allow two sync stages plus output registers
`timescale 1ns/10ps
`default_nettype none
`include "acac_defines.vh"
module acac_annunciator_monitor #(
	parameter AW = 4,
	parameter NUM_OUT = 8,
	parameter SCROLL_TIMEOUT_CYC = 50,
	parameter CADENCE_HALF_CYC = 4
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [7:0] paddr_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic alarm_evt_i,
	input wire logic [5:0] keys_i,
	input wire logic alarm_led_o,
	input wire logic buzzer_o,
	input wire logic [NUM_OUT-1:0] notification_appliance_circuit_o,
	input wire logic silenced_led_o,
	input wire logic disp_new_o,
	input wire logic disp_scroll_o,
	input wire logic [2:0] disp_cat_o,
	input wire logic [AW:0] disp_ordinal_o,
	input wire logic [AW:0] alarm_count_o
);
	logic [31:0] run_q;
	logic [31:0] idle_q;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// Counters stand in for long repetitions
	always @(posedge core_clk_i) begin
		run_q <= (rst_i || !buzzer_o) ? 32'h0 : run_q + 32'h1;
		idle_q <= (rst_i || keys_i[`ACAC_KEY_SCROLL]) ? 32'h0 : idle_q + 32'h1;
	end
	sequence press_s(b);
		$rose(b);
	endsequence
	sequence first_s;
		disp_cat_o == `ACAC_CAT_ALARM && disp_ordinal_o == 1;
	endsequence
	apb_ready_a: assert property (psel_i |-> pready_o) else $error("pready low");
	unmapped_err_a: assert property (psel_i && penable_i && paddr_i > 8'h10 |-> pslverr_o)
		else $error("no slave error");
	alarm_sound_a: assert property (alarm_evt_i |-> ##2 buzzer_o && disp_cat_o == 3'h1
		&& notification_appliance_circuit_o != 0) else $error("alarm not annunciated");
	first_stays_a: assert property ((alarm_evt_i && alarm_count_o != 0) and first_s |=> first_s[*3])
		else $error("display left first alarm");
	scroll_gate_a: assert property ((!disp_scroll_o)[*3] |-> disp_ordinal_o <= 1)
		else $error("scrolled with one event");
	ack_quiet_a: assert property (press_s(keys_i[`ACAC_KEY_ACK]) |-> ##8 !buzzer_o && !disp_new_o)
		else $error("ack left buzzer or new");
	silence_led_a: assert property (press_s(keys_i[`ACAC_KEY_SILENCE])
		&& notification_appliance_circuit_o != 0 |-> ##8 silenced_led_o) else $error("no silence");
	resound_on_a: assert property (press_s(keys_i[`ACAC_KEY_RESOUND]) && silenced_led_o
		|-> ##8 !silenced_led_o && notification_appliance_circuit_o != 0) else $error("no resound");
	reset_key_a: assert property (press_s(keys_i[`ACAC_KEY_RESET]) |-> ##8 alarm_count_o == 0
		&& !alarm_led_o && !buzzer_o && notification_appliance_circuit_o == 0) else $error("no reset");
	cadence_run_a: assert property ((disp_cat_o == 3'h1 && !disp_new_o)[*3]
		|-> run_q <= CADENCE_HALF_CYC) else $error("buzzer not pulsed");
	idle_return_a: assert property (idle_q > SCROLL_TIMEOUT_CYC + 10 && alarm_count_o != 0
		|-> first_s) else $error("no return to first alarm");
endmodule // acac_annunciator_monitor
bind acac_annunciator acac_annunciator_monitor #(.AW(AW), .NUM_OUT(NUM_OUT),
	.SCROLL_TIMEOUT_CYC(SCROLL_TIMEOUT_CYC), .CADENCE_HALF_CYC(CADENCE_HALF_CYC)) mon (
	.core_clk_i, .rst_i, .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o, .alarm_evt_i,
	.keys_i, .alarm_led_o, .buzzer_o, .notification_appliance_circuit_o, .silenced_led_o,
	.disp_new_o, .disp_scroll_o, .disp_cat_o, .disp_ordinal_o, .alarm_count_o);
`default_nettype wire

// File: testbench/acac_keypad.sv
// Purpose: Operator keypad model driving key levels
// Assumes: Keys are levels, high while pressed
// Notes: Hold time per call, so short and long presses occur
`timescale 1ns/10ps
`default_nettype none
module acac_keypad (
	input wire logic core_clk_i,
	output logic [5:0] keys_o
);
	initial keys_o = 6'h00;
	task automatic press(input int k, input int hold);
		@(posedge core_clk_i);
		keys_o[k] <= 1'b1;
		repeat (hold) @(posedge core_clk_i);
		keys_o[k] <= 1'b0;
		repeat (10) @(posedge core_clk_i);
		@(negedge core_clk_i);
	endtask
endmodule // acac_keypad
`default_nettype wire

// File: testbench/acac_annunciator_bench.sv
// Purpose: Directed run of the annunciator through alarm handling
// Assumes: Scroll timeout 50 cycles, cadence half period 4
// Notes: Checks land on falling edges, after outputs settle
`timescale 1ns/10ps
`default_nettype none
`include "acac_defines.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module acac_annunciator_bench;
	logic core_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, r;
	logic alarm_evt_i, mass_notification_evt_i, supv_evt_i, other_evt_i, e;
	logic [27:0] info;
	logic [5:0] keys_i;
	logic alarm_led_o, mass_notification_led_o, supv_led_o, buzzer_o, silenced_led_o;
	logic [7:0] notification_appliance_circuit_o;
	logic [2:0] disp_cat_o, hi, lo;
	logic [4:0] disp_ordinal_o, alarm_count_o, mass_notification_count_o, supv_count_o;
	logic disp_new_o, disp_scroll_o, show_other_o;
	logic [15:0] disp_zone_o, disp_zone_msg_addr_o, disp_dev_msg_addr_o, other_count_o;
	logic [3:0] disp_dev_type_o;
	logic [7:0] walk [4] = '{8'h22, 8'h41, 8'h81, 8'h21};
	int fail_count = 0;
	int comparisons = 0;
	acac_annunciator #(.SCROLL_TIMEOUT_CYC(50), .CADENCE_HALF_CYC(4)) uut (
		.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .alarm_evt_i, .alarm_info_i(info), .mass_notification_evt_i,
		.mass_notification_info_i(info), .supv_evt_i, .supv_info_i(info), .other_evt_i,
		.keys_i, .alarm_led_o, .mass_notification_led_o, .supv_led_o, .buzzer_o,
		.notification_appliance_circuit_o, .silenced_led_o, .disp_cat_o, .disp_ordinal_o,
		.disp_new_o, .disp_scroll_o, .disp_zone_o, .disp_zone_msg_addr_o,
		.disp_dev_msg_addr_o, .disp_dev_type_o, .alarm_count_o, .mass_notification_count_o,
		.supv_count_o, .show_other_o, .other_count_o);
	acac_keypad kp (.core_clk_i, .keys_o(keys_i));
	always #50 core_clk_i = ~core_clk_i;
	task complete_run;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk_i);
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			complete_run;
		end
		r = prdata_o;
		e = pslverr_o;
		{psel_i, penable_i} <= 2'b00;
		@(negedge core_clk_i);
	endtask
	// Category 0 alarm, 1 mass notification, 2 supervisory, 3 other
	task pulse(input int c, input logic [27:0] v);
		@(posedge core_clk_i);
		info <= v;
		{alarm_evt_i, mass_notification_evt_i, supv_evt_i, other_evt_i} <= 4'h8 >> c;
		@(posedge core_clk_i);
		{alarm_evt_i, mass_notification_evt_i, supv_evt_i, other_evt_i} <= 4'h0;
		repeat (3) @(negedge core_clk_i);
	endtask
	task watch;
		{hi, lo} = 6'h00;
		repeat (20) begin
			@(negedge core_clk_i);
			hi |= {buzzer_o, mass_notification_led_o, alarm_led_o};
			lo |= ~{buzzer_o, mass_notification_led_o, alarm_led_o};
		end
	endtask
	initial begin
		{core_clk_i, rst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {2'b01, 43'h0};
		{alarm_evt_i, mass_notification_evt_i, supv_evt_i, other_evt_i, info} = 32'h0;
		repeat (20) @(posedge core_clk_i);
		rst_i <= 1'b0;
		apb(0, 8'h00, 0);
		`CHK(r, 32'hFFFFFFFF)
		apb(0, 8'h04, 0);
		`CHK(r, 32'hFFFFFFFF)
		apb(0, 8'h14, 0);
		`CHK({e, r}, 33'h100000000)
		apb(1, 8'h08, 32'h3F);
		`CHK(e, 1'b1)
		$display("registers done");
		pulse(0, {16'h0007, 8'h05, 4'h3});
		`CHK({buzzer_o, disp_cat_o, disp_ordinal_o, disp_new_o}, 10'h243)
		`CHK({disp_zone_o, disp_zone_msg_addr_o, disp_dev_msg_addr_o}, 48'h000700E00082)
		`CHK({disp_dev_type_o, alarm_count_o, notification_appliance_circuit_o}, 17'h0_61FF)
		pulse(3, 28'h0);
		`CHK({other_count_o, show_other_o}, 17'h2)
		kp.press(`ACAC_KEY_VIEW, 3);
		`CHK(show_other_o, 1'b1)
		kp.press(`ACAC_KEY_VIEW, 6);
		kp.press(`ACAC_KEY_SCROLL, 3);
		`CHK({disp_cat_o, disp_ordinal_o}, 8'h21)
		pulse(0, {16'h0009, 8'h01, 4'h1});
		pulse(1, {16'h0002, 8'h02, 4'h2});
		pulse(2, {16'h0003, 8'h03, 4'h4});
		`CHK({disp_cat_o, disp_ordinal_o, disp_zone_o, disp_scroll_o}, 25'h420_00F)
		apb(0, 8'h0C, 0);
		`CHK(r, 32'h00010102)
		$display("events done");
		kp.press(`ACAC_KEY_ACK, 3);
		`CHK({buzzer_o, disp_new_o}, 2'b00)
		`CHK({supv_led_o, mass_notification_count_o, supv_count_o}, 11'h421)
		watch;
		`CHK({hi[0], lo[0]}, 2'b10)
		for (int i = 0; i < 4; i++) begin
			kp.press(`ACAC_KEY_SCROLL, i * 10 + 3);
			`CHK({disp_cat_o, disp_ordinal_o}, walk[i])
		end
		kp.press(`ACAC_KEY_SCROLL, 3);
		repeat (70) @(negedge core_clk_i);
		`CHK({disp_cat_o, disp_ordinal_o}, 8'h21)
		$display("scroll done");
		pulse(1, {16'h0004, 8'h04, 4'h2});
		watch;
		`CHK({hi, lo, mass_notification_count_o}, 11'h7_C2)
		apb(1, 8'h04, 32'hFE);
		kp.press(`ACAC_KEY_SILENCE, 3);
		`CHK({notification_appliance_circuit_o, silenced_led_o}, 9'h003)
		apb(0, 8'h08, 0);
		`CHK({r[4], r[0]}, 2'b11)
		kp.press(`ACAC_KEY_RESOUND, 3);
		`CHK({notification_appliance_circuit_o, silenced_led_o}, 9'h1FE)
		apb(1, 8'h00, 32'h0F);
		repeat (2) @(negedge core_clk_i);
		`CHK(notification_appliance_circuit_o, 8'h0F)
		$display("silence done");
		kp.press(`ACAC_KEY_RESET, 3);
		`CHK({alarm_count_o, mass_notification_count_o, supv_count_o, other_count_o}, 31'h0)
		`CHK({alarm_led_o, buzzer_o, notification_appliance_circuit_o}, 10'h0)
		$display("reset done");
		complete_run;
	end
endmodule // acac_annunciator_bench
`default_nettype wire
